//--- hdl/ssl_pkg.sv
// shared constants and types for the synthesizer serial latch loader
package ssl_pkg;
	localparam int WORD_W = 24;
	localparam int BYTE_W = 8;
	localparam int BYTES_PER_WORD = 3;
	localparam int CNT_W = 5;
	// latch select codes in the two low bits
	localparam logic [1:0] SEL_REF = 2'h0;
	localparam logic [1:0] SEL_DIV = 2'h1;
	localparam logic [1:0] SEL_FUNC = 2'h2;
	localparam logic [1:0] SEL_INIT = 2'h3;
	// function latch field positions
	localparam int POS_COUNTER_RESET = 2;
	localparam int POS_PD1 = 3;
	localparam int POS_MUX_LSB = 4;
	localparam int POS_PD2 = 21;
	localparam logic [2:0] MUX_LOCK_DETECT = 3'h1;
	localparam logic [23:0] LATCH_RESET = 24'h000000;
	// serial clock timing
	localparam int SYS_CLK_MHZ = 100;
	localparam int SCLK_MAX_MHZ = 20;
	// half period in system cycles, rounded up so the rate never exceeds the max
	localparam int SCLK_HALF_CYC = (SYS_CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
	localparam logic [3:0] HALF_CNT = 4'(SCLK_HALF_CYC - 1);
	typedef enum logic [1:0] {SSL_IDLE = 2'h0, SSL_LOW = 2'h1, SSL_HIGH = 2'h3, SSL_DONE = 2'h2}
		ssl_state_t;
endpackage

//--- hdl/ssl_if.sv
// three-wire link between host and synthesizer port
`timescale 1ns/1ps
interface ssl_if;
	logic serial_clock;
	logic serial_data;
	logic latch_strobe;
	modport host (output serial_clock, output serial_data, output latch_strobe);
	modport device (input serial_clock, input serial_data, input latch_strobe);
endinterface

//--- hdl/ssl_device.sv
// synthesizer end: shift register, latches, counter reset and power control
// Functional notes
// - host: func reset=1, ref, div, func reset=0
// - low bits 00 ref, 01 div, 10 func
// - counter reset holds counters, three-states pump
// - clearing counter reset releases counters aligned
// - shift on rising edge, latch on strobe rise
// - host serial clock at most 20 MHz
// - host: strobe low, three bytes, strobe high
// - host: four writes before output active
// - lock status on status output; power enable input
// - select 11 loads func latch plus reset pulse
// - power enable low powers down; register keeps loading
`timescale 1ns/1ps
module ssl_device (
	input wire logic sys_clk,
	input wire logic resetn,
	ssl_if.device link,
	input wire logic chip_power_enable,
	input wire logic lock_detect,
	output logic [23:0] ref_latch,
	output logic [23:0] div_latch,
	output logic [23:0] func_latch,
	output logic counters_held,
	output logic charge_pump_tristate,
	output logic power_down,
	output logic multiplexed_status_output,
	output logic output_active
);
	logic [1:0] sclk_sync;
	logic [1:0] data_sync;
	logic [1:0] strobe_sync;
	logic sclk_prev;
	logic strobe_prev;
	logic [23:0] shift;
	logic [23:0] next_shift;
	logic [23:0] next_ref;
	logic [23:0] next_div;
	logic [23:0] next_func;
	// set by an init write, cleared by the first divider load after it
	logic init_pending;
	logic next_init_pending;
	logic reset_pulse;
	logic next_reset_pulse;
	logic [3:0] written;
	logic [3:0] next_written;
	logic next_held;
	logic next_tri;
	logic next_pd;
	logic next_mux;
	logic power_sync;
	logic power_meta;
	logic lock_meta;
	logic lock_sync;
	logic sclk_rise;
	logic strobe_rise;

	// pins cross into sys_clk; only the second stage is read
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclk_sync <= 2'h0;
			data_sync <= 2'h0;
			// strobe idles high; a low seed would fake a latch after reset
			strobe_sync <= 2'h3;
			sclk_prev <= 1'b0;
			strobe_prev <= 1'b1;
			power_meta <= 1'b0;
			power_sync <= 1'b0;
			lock_meta <= 1'b0;
			lock_sync <= 1'b0;
		end
		else
		begin
			sclk_sync <= {sclk_sync[0], link.serial_clock};
			data_sync <= {data_sync[0], link.serial_data};
			strobe_sync <= {strobe_sync[0], link.latch_strobe};
			sclk_prev <= sclk_sync[1];
			strobe_prev <= strobe_sync[1];
			// lock comes from the analog side, so it is resynchronised too
			power_meta <= chip_power_enable;
			power_sync <= power_meta;
			lock_meta <= lock_detect;
			lock_sync <= lock_meta;
		end
	end

	// clock and data share one sync depth, so data is settled at a seen rise
	assign sclk_rise = sclk_sync[1] & ~sclk_prev;
	assign strobe_rise = strobe_sync[1] & ~strobe_prev;

	always_comb
	begin
		next_shift = shift;
		next_ref = ref_latch;
		next_div = div_latch;
		next_func = func_latch;
		next_init_pending = init_pending;
		// pulse lasts one cycle; only init or its first divider load raise it
		next_reset_pulse = 1'b0;
		next_written = written;
		if (sclk_rise)
			next_shift = {shift[22:0], data_sync[1]};
		if (strobe_rise)
		begin
			unique case (shift[1:0])
				ssl_pkg::SEL_REF:
				begin
					next_ref = shift;
					next_written[0] = 1'b1;
				end
				ssl_pkg::SEL_DIV:
				begin
					next_div = shift;
					next_written[1] = 1'b1;
					// first divider load after init repeats the pulse
					if (init_pending)
					begin
						next_reset_pulse = 1'b1;
						next_init_pending = 1'b0;
					end
				end
				ssl_pkg::SEL_FUNC:
				begin
					next_func = shift;
					next_written[2] = 1'b1;
				end
				ssl_pkg::SEL_INIT:
				begin
					next_func = shift;
					next_reset_pulse = 1'b1;
					next_init_pending = 1'b1;
					next_written[3] = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			shift <= ssl_pkg::LATCH_RESET;
			ref_latch <= ssl_pkg::LATCH_RESET;
			div_latch <= ssl_pkg::LATCH_RESET;
			func_latch <= ssl_pkg::LATCH_RESET;
			init_pending <= 1'b0;
			reset_pulse <= 1'b0;
			written <= 4'h0;
		end
		else
		begin
			shift <= next_shift;
			ref_latch <= next_ref;
			div_latch <= next_div;
			func_latch <= next_func;
			init_pending <= next_init_pending;
			reset_pulse <= next_reset_pulse;
			written <= next_written;
		end
	end

	always_comb
	begin
		next_pd = ~power_sync;
		// asynchronous programmed power-down: PD1 set with PD2 clear
		if (func_latch[ssl_pkg::POS_PD1] && !func_latch[ssl_pkg::POS_PD2])
			next_pd = 1'b1;
		// power-down parks the counters too, so it holds them
		// hold and tristate
		next_held = func_latch[ssl_pkg::POS_COUNTER_RESET] | reset_pulse | next_pd;
		next_tri = next_held;
		next_mux = (func_latch[ssl_pkg::POS_MUX_LSB +: 3] == ssl_pkg::MUX_LOCK_DETECT)
			? lock_sync : 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			counters_held <= 1'b1;
			charge_pump_tristate <= 1'b1;
			power_down <= 1'b1;
			multiplexed_status_output <= 1'b0;
			output_active <= 1'b0;
		end
		else
		begin
			counters_held <= next_held;
			charge_pump_tristate <= next_tri;
			power_down <= next_pd;
			multiplexed_status_output <= next_mux;
			// built from next_held so active never leads held by a cycle
			// all four select codes written (00 ref, 01 div, 10 func, 11 init)
			output_active <= (&written) & ~next_held;
		end
	end
endmodule // ssl_device

//--- hdl/ssl_host.sv
// host end: sends one 24-bit word per request as three bytes
`timescale 1ns/1ps
module ssl_host (
	input wire logic sys_clk,
	input wire logic resetn,
	ssl_if.host link,
	input wire logic req_valid,
	input wire logic [23:0] req_word,
	output logic req_ready,
	output logic done
);
	ssl_pkg::ssl_state_t state;
	ssl_pkg::ssl_state_t next_state;
	logic [23:0] word;
	logic [23:0] next_word;
	logic [4:0] bits;
	logic [4:0] next_bits;
	logic [3:0] tick;
	logic [3:0] next_tick;
	logic next_sclk;
	logic next_strobe;
	logic next_ready;
	logic next_done;

	always_comb
	begin
		next_state = state;
		next_word = word;
		next_bits = bits;
		next_tick = tick;
		next_sclk = link.serial_clock;
		next_strobe = link.latch_strobe;
		next_ready = 1'b0;
		next_done = 1'b0;
		if (tick != 4'h0)
			next_tick = tick - 4'h1;
		unique case (state)
			ssl_pkg::SSL_IDLE:
			begin
				next_ready = 1'b1;
				if (req_valid && req_ready)
				begin
					next_word = req_word;
					next_bits = 5'(ssl_pkg::WORD_W);
					next_strobe = 1'b0;
					next_ready = 1'b0;
					next_tick = ssl_pkg::HALF_CNT;
					next_state = ssl_pkg::SSL_LOW;
				end
			end
			ssl_pkg::SSL_LOW:
				if (tick == 4'h0)
				begin
					next_sclk = 1'b1;
					next_tick = ssl_pkg::HALF_CNT;
					next_bits = bits - 5'h1;
					next_state = ssl_pkg::SSL_HIGH;
				end
			ssl_pkg::SSL_HIGH:
				if (tick == 4'h0)
				begin
					next_sclk = 1'b0;
					next_tick = ssl_pkg::HALF_CNT;
					next_word = {word[22:0], 1'b0};
					next_state = (bits == 5'h0) ? ssl_pkg::SSL_DONE : ssl_pkg::SSL_LOW;
				end
			ssl_pkg::SSL_DONE:
				if (tick == 4'h0)
				begin
					next_strobe = 1'b1;
					next_done = 1'b1;
					next_state = ssl_pkg::SSL_IDLE;
				end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= ssl_pkg::SSL_IDLE;
			word <= ssl_pkg::LATCH_RESET;
			bits <= 5'h00;
			tick <= 4'h0;
			link.serial_clock <= 1'b0;
			link.serial_data <= 1'b0;
			link.latch_strobe <= 1'b1;
			req_ready <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			state <= next_state;
			word <= next_word;
			bits <= next_bits;
			tick <= next_tick;
			link.serial_clock <= next_sclk;
			link.serial_data <= next_word[23];
			link.latch_strobe <= next_strobe;
			req_ready <= next_ready;
			done <= next_done;
		end
	end
endmodule // ssl_host

//--- test/ssl_monitor.sv
// link protocol checker for the serial latch loader
`timescale 1ns/1ps
module ssl_monitor (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic latch_strobe
);
	logic [4:0] bits;
	logic [4:0] next_bits;
	logic prev_clk;
	logic next_prev_clk;
	// counted in logic, too long to unroll
	always_comb
	begin
		next_prev_clk = serial_clock;
		next_bits = bits;
		if (latch_strobe)
			next_bits = 5'h00;
		else if (serial_clock && !prev_clk)
			next_bits = bits + 5'h01;
	end
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bits <= 5'h00;
			prev_clk <= 1'b0;
		end
		else
		begin
			bits <= next_bits;
			prev_clk <= next_prev_clk;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_high;
		serial_clock [*3] ##1 !serial_clock;
	endsequence
	sequence s_low;
		!serial_clock [*3];
	endsequence
	AST_HIGH_HALF: assert property ($rose(serial_clock) |-> s_high)
		else $error("clock high phase");
	AST_LOW_HALF: assert property ($fell(serial_clock) && !latch_strobe |-> s_low)
		else $error("clock low phase");
	AST_DATA_HELD: assert property (serial_clock |-> $stable(serial_data))
		else $error("data moved while clock high");
	AST_IDLE_CLK: assert property (latch_strobe |-> !serial_clock)
		else $error("clock outside frame");
	AST_FIRST_LOW: assert property ($fell(latch_strobe) |-> s_low)
		else $error("frame start");
	AST_WORD_BITS: assert property ($rose(latch_strobe) |-> bits == 5'h18)
		else $error("bit count");
	AST_FRAME_LEN: assert property ($fell(latch_strobe) |-> ##[144:152] $rose(latch_strobe))
		else $error("frame length");
	AST_STROBE_END: assert property ($rose(latch_strobe) |-> !$past(serial_clock))
		else $error("strobe rose with clock high");
endmodule // ssl_monitor

//--- test/synth_serial_latch_loader_tb_top.sv
// bench joining host and device ends of the serial latch loader
`timescale 1ns/1ps
module synth_serial_latch_loader_tb_top;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	logic [23:0] req_word = 24'h000000;
	logic chip_power_enable = 1'b1;
	logic lock_detect = 1'b0;
	logic prev_sc = 1'b0;
	logic req_ready, done, held, tri_st, pd, mso, active;
	logic [23:0] ref_latch, div_latch, func_latch, f;
	logic [23:0] cap = 24'h000000;
	logic [23:0] m [4];
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int held_cycles = 0;
	int hc = 0;
	ssl_if link();
	ssl_host u_ssl_host (.sys_clk(sys_clk), .resetn(resetn), .link(link.host),
		.req_valid(req_valid), .req_word(req_word), .req_ready(req_ready), .done(done));
	ssl_device u_ssl_device (.sys_clk(sys_clk), .resetn(resetn), .link(link.device),
		.chip_power_enable(chip_power_enable), .lock_detect(lock_detect),
		.ref_latch(ref_latch), .div_latch(div_latch), .func_latch(func_latch),
		.counters_held(held), .charge_pump_tristate(tri_st), .power_down(pd),
		.multiplexed_status_output(mso), .output_active(active));
	ssl_monitor u_ssl_monitor (.sys_clk(sys_clk), .resetn(resetn),
		.serial_clock(link.serial_clock), .serial_data(link.serial_data),
		.latch_strobe(link.latch_strobe));
	always #5 sys_clk = ~sys_clk;
	// wire capture, independent of the device
	always @(posedge sys_clk)
	begin
		prev_sc <= link.serial_clock;
		if (link.serial_clock && !prev_sc)
			cap <= {cap[22:0], link.serial_data};
		cycles <= cycles + 1;
		held_cycles <= held_cycles + int'(held === 1'b1);
		if (cycles == 6000)
		begin
			num_errors++;
			stop_test();
		end
	end
	function automatic logic [23:0] rnd();
		return 24'($urandom());
	endfunction
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [23:0] w);
		while (req_ready !== 1'b1) @(negedge sys_clk);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_word <= w;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		while (done !== 1'b1) @(negedge sys_clk);
		repeat (8) @(negedge sys_clk);
		m[w[1:0]] = w;
		if (w[1:0] == 2'h3)
			m[2] = w;
		chk(cap, w);
		chk(ref_latch, m[0]);
		chk(div_latch, m[1]);
		chk(func_latch, m[2]);
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(29400));
		m = '{default: 24'h000000};
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		chk(24'({active, pd}), 24'h000001);
		// status on lock, power bits clear
		f = (rnd() & 24'hDFFF80) | 24'h000010;
		repeat (4) @(negedge sys_clk);
		hc = held_cycles;
		wr(f | 24'h000003);
		chk(24'(held_cycles != hc), 24'h000001);
		wr(f | 24'h000006);
		chk(24'({held, tri_st}), 24'h000003);
		wr(rnd() & 24'hFFFFFC);
		wr((rnd() & 24'hFFFFFC) | 24'h000001);
		chk(24'({held, tri_st}), 24'h000003);
		wr(f | 24'h000002);
		chk(24'({held, active, pd}), 24'h000002);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk);
			lock_detect <= 1'($urandom());
			repeat (6) @(negedge sys_clk);
			chk(24'(mso), 24'(lock_detect));
		end
		@(posedge sys_clk);
		chip_power_enable <= 1'b0;
		repeat (6) @(negedge sys_clk);
		chk(24'(pd), 24'h000001);
		// loads go on while powered down
		for (int i = 0; i < 8; i++)
			wr((rnd() & 24'hFFFFFC) | 24'(i % 4));
		stop_test();
	end
endmodule // synth_serial_latch_loader_tb_top
